// >>> nibble_dram_defs.svh
// Timing, geometry and init constants for the nibble DRAM controller
`ifndef NIBBLE_DRAM_DEFS_SVH
`define NIBBLE_DRAM_DEFS_SVH

// Controller clock period in ns (250 MHz)
`define CLK_NS          4
// Least time rounds up, longest rounds down, never below one cycle
`define CYC_UP(ns)      ((((ns) + `CLK_NS - 1) / `CLK_NS) > 0 ? \
                         (((ns) + `CLK_NS - 1) / `CLK_NS) : 1)
`define CYC_DN(ns)      (((ns) / `CLK_NS) > 0 ? ((ns) / `CLK_NS) : 1)

// Geometry
`define ROW_BITS        11
`define COL_BITS        11
`define ADDR_BITS       22
`define REF_ROWS        1024
`define REF_ROW_BITS    10
`define INIT_CYCLES     8
`define WAIT_BITS       16
`define RAS_CNT_BITS    8
`define SYNC_LAT        3

// Power-up pause and refresh period, in ns
`define T_PAUSE_NS      200000
`define T_REF_NS        16400000

// Speed grade timing set in ns; swap these to serve another grade
`define T_RP            65
`define T_RC            155
`define T_RAH           12
`define T_ROW_COL       22
`define T_ROW_ACC       80
`define T_COL_ACC       25
`define T_COL_WR_DLY    25
`define T_ROW_WR_DLY    80
`define T_COL_LEAD      20
`define T_ROW_LEAD      25
`define T_CBR_SETUP     0
`define T_CHR           15
`define T_NCP           15
`define T_NIB_ACC       45

`endif

// >>> nibble_dram_pkg.sv
// Types shared by the nibble DRAM controller files
package nibble_dram_pkg;

	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_RMW   = 2'h2
	} op_type;

	// User request; nib_len is the number of extra nibble beats (0..3)
	typedef struct packed {
		op_type       op;
		logic [21:0]  addr;
		logic [3:0]   wdata;
		logic [1:0]   nib_len;
	} req_type;

	// Strobes, address and data toward the memory pins
	typedef struct packed {
		logic         ras_n;
		logic         cas_n;
		logic         we_n;
		logic [10:0]  addr;
		logic         din;
	} pins_type;

	typedef enum logic [11:0] {
		ST_PAUSE   = 12'h001,
		ST_IDLE    = 12'h002,
		ST_ROW     = 12'h004,
		ST_COLADR  = 12'h008,
		ST_CAS     = 12'h010,
		ST_WR      = 12'h020,
		ST_NIB_PRE = 12'h040,
		ST_END     = 12'h080,
		ST_PRE     = 12'h100,
		ST_CBR     = 12'h200,
		ST_REF_ACT = 12'h400,
		ST_HID_PRE = 12'h800
	} state_type;

endpackage

// >>> nibble_dram_sync.sv
// Three-stage synchroniser that passes a level once two stages agree
`timescale 1ns/1ps
`include "nibble_dram_defs.svh"

module nibble_dram_sync (
	// Clock and control
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Asynchronous level in, clean level out
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_q;
	logic stage2_q;
	logic stage3_q;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			meta_q   <= 1'b0;
			stage2_q <= 1'b0;
			stage3_q <= 1'b0;
		end else if (ce_i) begin
			meta_q   <= async_i;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
		end
	end

	// Only the settled stages are compared, never the first one
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sync_o <= 1'b0;
		end else if (ce_i && (stage2_q == stage3_q)) begin
			sync_o <= stage3_q;
		end
	end

endmodule

// >>> nibble_dram_ctrl.sv
// Host-side cycle controller for a 4M x 1 nibble-mode DRAM
//
// How it works
// - Hold strobes high 200 us after reset, then eight refresh cycles.
// - Internal-counter mode uses eight column-before-row cycles for wake-up.
// - One refresh per row interval covers 1024 rows every 16.4 ms.
// - Read keeps both strobes low, write strobe high, row then column.
// - Write strobe stays high until after both strobes rise in reads.
// - Delayed-style write keeps write-to-strobe and address lead times.
// - Row-only refresh holds row strobe low, column strobe high.
// - Column-before-row refresh lowers column strobe first, write high.
// - Eleven row bits then eleven column bits on the shared pins.
`timescale 1ns/1ps
`include "nibble_dram_defs.svh"

module nibble_dram_ctrl #(
	parameter int unsigned INIT_PAUSE_CYC = `CYC_UP(`T_PAUSE_NS),
	parameter bit          USE_CBR        = 1'b1
) (
	// Clock, reset, enable
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      ce_i,
	// Request port
	input  wire logic                      req_valid_i,
	input  wire nibble_dram_pkg::req_type  req_i,
	output logic                           req_ready_o,
	// Read data beats and init done flag
	output logic                           rd_valid_o,
	output logic                           rd_data_o,
	output logic                           init_done_o,
	// Memory pins
	output nibble_dram_pkg::pins_type      pins_o,
	input  wire logic                      dout_i
);

	localparam int unsigned RAS_MIN = `CYC_UP(`T_RC - `T_RP);
	localparam int unsigned RD_RAS  = `CYC_UP(`T_ROW_ACC) + `SYNC_LAT;
	localparam int unsigned RD_CAS  = `CYC_UP(`T_COL_ACC) + `SYNC_LAT;
	localparam int unsigned NIB_RD  = `CYC_UP(`T_NIB_ACC - `T_NCP) + `SYNC_LAT;
	localparam int unsigned WR_HOLD = `CYC_UP(`T_ROW_LEAD > `T_COL_LEAD ?
	                                          `T_ROW_LEAD : `T_COL_LEAD);
	localparam int unsigned REF_CYC = `CYC_DN(`T_REF_NS / `REF_ROWS);

	nibble_dram_pkg::state_type state_q;
	nibble_dram_pkg::req_type   cmd_q;
	logic [`WAIT_BITS-1:0]      wait_q;
	logic [`RAS_CNT_BITS-1:0]   ras_cnt_q;
	logic [`WAIT_BITS-1:0]      ref_tmr_q;
	logic                       ref_pend_q;
	logic [`REF_ROW_BITS-1:0]   ref_row_q;
	logic [3:0]                 init_cnt_q;
	logic [1:0]                 beats_q;
	logic                       dout_sync;
	logic                       ref_start;
	logic                       wait_done;
	logic                       ras_ok;

	nibble_dram_sync u_dout_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.async_i   (dout_i),
		.sync_o    (dout_sync)
	);

	assign wait_done   = (wait_q == '0);
	assign ras_ok      = (ras_cnt_q >= `RAS_CNT_BITS'(RAS_MIN));
	assign req_ready_o = (state_q == nibble_dram_pkg::ST_IDLE) &&
	                     init_done_o && !ref_pend_q;
	// Refresh (or init cycle) begins from idle, or hidden after a read
	assign ref_start   = ((state_q == nibble_dram_pkg::ST_IDLE) &&
	                      (ref_pend_q || !init_done_o)) ||
	                     ((state_q == nibble_dram_pkg::ST_HID_PRE) &&
	                      wait_done);

	// Row interval timer; a new tick beats a clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ref_tmr_q  <= '0;
			ref_pend_q <= 1'b0;
		end else if (ce_i && init_done_o) begin
			if (ref_tmr_q == `WAIT_BITS'(REF_CYC - 1)) begin
				ref_tmr_q  <= '0;
				ref_pend_q <= 1'b1;
			end else begin
				ref_tmr_q <= ref_tmr_q + 1'b1;
				if (ref_start) begin
					ref_pend_q <= 1'b0;
				end
			end
		end
	end

	// Row strobe low-time counter, saturating
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ras_cnt_q <= '0;
		end else if (ce_i) begin
			if (pins_o.ras_n) begin
				ras_cnt_q <= '0;
			end else if (ras_cnt_q != '1) begin
				ras_cnt_q <= ras_cnt_q + 1'b1;
			end
		end
	end

	// Main cycle sequencer: strobes, address, data and waits
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_q     <= nibble_dram_pkg::ST_PAUSE;
			pins_o      <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
			                 addr: '0, din: 1'b0};
			wait_q      <= `WAIT_BITS'(INIT_PAUSE_CYC);
			cmd_q       <= '0;
			beats_q     <= '0;
			init_cnt_q  <= '0;
			init_done_o <= 1'b0;
			ref_row_q   <= '0;
			rd_valid_o  <= 1'b0;
			rd_data_o   <= 1'b0;
		end else if (ce_i) begin
			rd_valid_o <= 1'b0;
			if (!wait_done) begin
				wait_q <= wait_q - 1'b1;
			end
			case (state_q)
			nibble_dram_pkg::ST_PAUSE: begin
				if (wait_done) begin
					state_q <= nibble_dram_pkg::ST_IDLE;
				end
			end
			nibble_dram_pkg::ST_IDLE: begin
				if (ref_start) begin
					if (USE_CBR) begin
						pins_o.cas_n <= 1'b0;
						pins_o.we_n  <= 1'b1;
						wait_q       <= `WAIT_BITS'(`CYC_UP(`T_CBR_SETUP));
						state_q      <= nibble_dram_pkg::ST_CBR;
					end else begin
						pins_o.addr  <= {1'b0, ref_row_q};
						pins_o.ras_n <= 1'b0;
						ref_row_q    <= ref_row_q + 1'b1;
						state_q      <= nibble_dram_pkg::ST_REF_ACT;
					end
				end else if (req_valid_i) begin
					cmd_q        <= req_i;
					beats_q      <= req_i.nib_len;
					// Row half of the address first
					pins_o.addr  <= req_i.addr[`ADDR_BITS-1:`COL_BITS];
					pins_o.ras_n <= 1'b0;
					// Early write: write strobe low well ahead
					pins_o.we_n  <= (req_i.op != nibble_dram_pkg::OP_WRITE);
					pins_o.din   <= req_i.wdata[0];
					wait_q       <= `WAIT_BITS'(`CYC_UP(`T_RAH));
					state_q      <= nibble_dram_pkg::ST_ROW;
				end
			end
			nibble_dram_pkg::ST_ROW: begin
				if (wait_done) begin
					pins_o.addr <= cmd_q.addr[`COL_BITS-1:0];
					wait_q      <= `WAIT_BITS'(`CYC_UP(`T_ROW_COL - `T_RAH));
					state_q     <= nibble_dram_pkg::ST_COLADR;
				end
			end
			nibble_dram_pkg::ST_COLADR: begin
				if (wait_done) begin
					pins_o.cas_n <= 1'b0;
					wait_q <= (cmd_q.op == nibble_dram_pkg::OP_WRITE) ?
					          `WAIT_BITS'(WR_HOLD) : `WAIT_BITS'(RD_CAS);
					state_q <= nibble_dram_pkg::ST_CAS;
				end
			end
			nibble_dram_pkg::ST_CAS: begin
				if (cmd_q.op == nibble_dram_pkg::OP_WRITE) begin
					if (wait_done) begin
						state_q <= (beats_q != '0) ?
						           nibble_dram_pkg::ST_NIB_PRE :
						           nibble_dram_pkg::ST_END;
						wait_q  <= `WAIT_BITS'(`CYC_UP(`T_NCP));
					end
				end else if (wait_done &&
				             ras_cnt_q >= `RAS_CNT_BITS'(RD_RAS)) begin
					// Sampled while column strobe is still low
					rd_data_o  <= dout_sync;
					rd_valid_o <= 1'b1;
					if (cmd_q.op == nibble_dram_pkg::OP_RMW) begin
						// Read done, so column/row-to-write delays met
						pins_o.we_n <= 1'b0;
						wait_q      <= `WAIT_BITS'(WR_HOLD);
						state_q     <= nibble_dram_pkg::ST_WR;
					end else begin
						wait_q  <= `WAIT_BITS'(`CYC_UP(`T_NCP));
						state_q <= (beats_q != '0) ?
						           nibble_dram_pkg::ST_NIB_PRE :
						           nibble_dram_pkg::ST_END;
					end
				end
			end
			nibble_dram_pkg::ST_WR: begin
				if (wait_done) begin
					wait_q  <= `WAIT_BITS'(`CYC_UP(`T_NCP));
					state_q <= (beats_q != '0) ?
					           nibble_dram_pkg::ST_NIB_PRE :
					           nibble_dram_pkg::ST_END;
				end
			end
			nibble_dram_pkg::ST_NIB_PRE: begin
				// Rising column strobe steps the column
				pins_o.cas_n <= 1'b1;
				if (cmd_q.op == nibble_dram_pkg::OP_RMW) begin
					pins_o.we_n <= 1'b1;
				end
				if (wait_done && pins_o.cas_n) begin
					beats_q      <= beats_q - 1'b1;
					pins_o.din   <= cmd_q.wdata[2'(cmd_q.nib_len -
					                               beats_q + 1'b1)];
					pins_o.cas_n <= 1'b0;
					wait_q <= (cmd_q.op == nibble_dram_pkg::OP_WRITE) ?
					          `WAIT_BITS'(WR_HOLD) : `WAIT_BITS'(NIB_RD);
					state_q <= nibble_dram_pkg::ST_CAS;
				end
			end
			nibble_dram_pkg::ST_END: begin
				if (ref_pend_q && USE_CBR &&
				    cmd_q.op == nibble_dram_pkg::OP_READ && ras_ok) begin
					// Column strobe stays low so the read data holds
					pins_o.ras_n <= 1'b1;
					wait_q       <= `WAIT_BITS'(`CYC_UP(`T_RP));
					state_q      <= nibble_dram_pkg::ST_HID_PRE;
				end else begin
					pins_o.cas_n <= 1'b1;
					if (ras_ok && pins_o.cas_n) begin
						pins_o.ras_n <= 1'b1;
						wait_q       <= `WAIT_BITS'(`CYC_UP(`T_RP));
						state_q      <= nibble_dram_pkg::ST_PRE;
					end
				end
			end
			nibble_dram_pkg::ST_PRE: begin
				// Write strobe rises here with row strobe high; RMW nibble beats raise it earlier in ST_NIB_PRE
				pins_o.we_n <= 1'b1;
				if (wait_done) begin
					state_q <= nibble_dram_pkg::ST_IDLE;
				end
			end
			nibble_dram_pkg::ST_HID_PRE: begin
				if (wait_done) begin
					pins_o.ras_n <= 1'b0;
					state_q      <= nibble_dram_pkg::ST_REF_ACT;
				end
			end
			nibble_dram_pkg::ST_CBR: begin
				if (wait_done) begin
					pins_o.ras_n <= 1'b0;
					state_q      <= nibble_dram_pkg::ST_REF_ACT;
				end
			end
			nibble_dram_pkg::ST_REF_ACT: begin
				// Low time covers column hold after row strobe too
				if (ras_ok) begin
					pins_o.ras_n <= 1'b1;
					pins_o.cas_n <= 1'b1;
					wait_q       <= `WAIT_BITS'(`CYC_UP(`T_RP));
					state_q      <= nibble_dram_pkg::ST_PRE;
					if (!init_done_o) begin
						init_cnt_q <= init_cnt_q + 1'b1;
						if (init_cnt_q == 4'(`INIT_CYCLES - 1)) begin
							init_done_o <= 1'b1;
						end
					end
				end
			end
			default: begin
				state_q <= nibble_dram_pkg::ST_IDLE;
			end
			endcase
		end
	end

endmodule

// >>> dram_model.sv
// Behavioural model of the 4M x 1 nibble-mode DRAM
`timescale 1ns/1ps
module dram_model (
	// Strobes, address and data in
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [10:0] addr,
	input  wire logic        din,
	// Data out
	output logic             dout
);
	logic        mem [int];
	logic [10:0] row;
	logic [10:0] col;
	logic        nib;
	initial dout = 1'b0;
	always @(negedge ras_n) if (cas_n) begin
		row = addr;
		nib = 1'b0;
	end
	always @(negedge cas_n) if (!ras_n) begin
		// Column latched once; later falls are nibble beats
		if (!nib) col = addr;
		nib = 1'b1;
		if (!we_n) mem[{row, col}] = din;
		else dout <= #25 mem.exists({row, col}) ? mem[{row, col}] : 1'b0;
	end
	// Off the bus: show a changed level, not a stale one
	always @(posedge cas_n) begin
		dout <= #5 ~dout;
		if (!ras_n) col[1:0] = col[1:0] + 2'h1;
	end
	always @(negedge we_n) if (!cas_n && !ras_n) mem[{row, col}] = din;
	// Ras cycling under a low cas leaves dout alone
endmodule

// >>> nibble_dram_ctrl_assertions.sv
// Port-level assertions for the nibble DRAM controller
`timescale 1ns/1ps
module nibble_dram_ctrl_assertions #(
	parameter int unsigned INIT_PAUSE_CYC = 20,
	parameter bit          USE_CBR        = 1'b1
) (
	// Clock, reset, enable
	input wire logic                      sys_clk_i,
	input wire logic                      rst_i,
	input wire logic                      ce_i,
	// Request side
	input wire logic                      req_valid_i,
	input wire nibble_dram_pkg::req_type  req_i,
	input wire logic                      req_ready_o,
	input wire logic                      rd_valid_o,
	input wire logic                      rd_data_o,
	input wire logic                      init_done_o,
	// Memory side
	input wire nibble_dram_pkg::pins_type pins_o,
	input wire logic                      dout_i
);
	logic [15:0] hi_q;
	logic [7:0]  lo_q;
	logic        seen_q;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !pins_o.ras_n) hi_q <= 16'h0;
		else if (hi_q != 16'hffff) hi_q <= hi_q + 16'h1;
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || pins_o.ras_n) lo_q <= 8'h0;
		else if (lo_q != 8'hff) lo_q <= lo_q + 8'h1;
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) seen_q <= 1'b0;
		else if (!pins_o.ras_n) seen_q <= 1'b1;
	end
	reset_idle_a: assert property (disable iff (1'b0) rst_i |=>
		pins_o.ras_n && pins_o.cas_n && pins_o.we_n) else $error("strobes busy after reset");
	pause_len_a: assert property ($fell(pins_o.ras_n) && !seen_q |->
		hi_q >= INIT_PAUSE_CYC) else $error("power-up pause too short");
	ras_pre_a: assert property ($fell(pins_o.ras_n) |-> hi_q >= 17)
		else $error("row strobe precharge too short");
	ras_width_a: assert property ($rose(pins_o.ras_n) |-> lo_q >= 20)
		else $error("row strobe pulse too short");
	early_ready_a: assert property (!init_done_o |-> !req_ready_o)
		else $error("ready before init done");
	ready_idle_a: assert property (req_ready_o |-> pins_o.ras_n && pins_o.cas_n)
		else $error("ready while strobes active");
	cbr_order_a: assert property ($fell(pins_o.cas_n) && pins_o.ras_n |->
		pins_o.we_n ##[1:2] !pins_o.ras_n) else $error("bad refresh order");
	// Read-modify-write lowers the write strobe on the sampling edge itself
	read_window_a: assert property (rd_valid_o |->
		!pins_o.cas_n && $past(pins_o.we_n))
		else $error("read beat outside read window");
	col_stable_a: assert property ($fell(pins_o.cas_n) && !pins_o.ras_n |->
		$stable(pins_o.addr)) else $error("column address moved at strobe");
	write_in_row_a: assert property ($fell(pins_o.we_n) |-> !pins_o.ras_n)
		else $error("write strobe outside row cycle");
	din_hold_a: assert property (($fell(pins_o.cas_n) && !pins_o.we_n) ||
		($fell(pins_o.we_n) && !pins_o.cas_n) |=> $stable(pins_o.din)[*3])
		else $error("data in not held");
	cover property (rd_valid_o);
	cover property ($fell(pins_o.cas_n) && pins_o.ras_n);
	cover property ($fell(pins_o.we_n) && !pins_o.cas_n);
	cover property ($rose(pins_o.ras_n) && !pins_o.cas_n);
endmodule

// >>> test_nibble_dram_ctrl.sv
// Self-checking bench for the nibble DRAM controller
`timescale 1ns/1ps
module test_nibble_dram_ctrl;
	localparam int unsigned PAUSE = 20;
	typedef struct packed {
		nibble_dram_pkg::req_type req;
		logic [3:0]               exp;
	} row_type;
	logic                      sys_clk_i = 1'b0;
	logic                      rst_i = 1'b1;
	logic                      ce_i = 1'b1;
	logic                      req_valid_i = 1'b0;
	nibble_dram_pkg::req_type  req_i = '0;
	logic                      req_ready_o;
	logic                      rd_valid_o;
	logic                      rd_data_o;
	logic                      init_done_o;
	nibble_dram_pkg::pins_type pins_o;
	logic                      dout_i;
	int                        n_fail = 0;
	int                        cmp_count = 0;
	int                        falls = 0;
	logic                      ras_prev = 1'b1;
	row_type                   rows [6];

	always #2 sys_clk_i = ~sys_clk_i;

	nibble_dram_ctrl #(.INIT_PAUSE_CYC(PAUSE), .USE_CBR(1'b1)) u_dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
		.init_done_o(init_done_o), .pins_o(pins_o), .dout_i(dout_i));
	dram_model u_mem (.ras_n(pins_o.ras_n), .cas_n(pins_o.cas_n),
		.we_n(pins_o.we_n), .addr(pins_o.addr), .din(pins_o.din),
		.dout(dout_i));

	// Count row strobe falls away from the launching edge
	always @(negedge sys_clk_i) begin
		if (ras_prev && !pins_o.ras_n) falls++;
		ras_prev = pins_o.ras_n;
	end

	function automatic row_type mk(input logic [1:0] op, input logic [21:0] a,
			input logic [3:0] w, input logic [1:0] n, input logic [3:0] e);
		return '{'{nibble_dram_pkg::op_type'(op), a, w, n}, e};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask

	task automatic wait_hi(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
		if (s !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: wait ran out", $time);
		end
	endtask

	task automatic do_req(input row_type r);
		int b;
		wait_hi(req_ready_o, 20000);
		req_i = r.req;
		req_valid_i = 1'b1;
		tick(1);
		req_valid_i = 1'b0;
		if (r.req.op != nibble_dram_pkg::OP_WRITE)
			for (b = 0; b <= r.req.nib_len; b++) begin
				wait_hi(rd_valid_o, 400);
				chk(rd_data_o, r.exp[b]);
				tick(1);
			end
	endtask

	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		#300000;
		n_fail++;
		$display("wrong value at %0t: run did not finish", $time);
		close_out();
	end

	initial begin
		int i;
		rows[0] = mk(2'h1, 22'h012345, 4'h9, 2'h3, 4'h0);
		rows[1] = mk(2'h0, 22'h012345, 4'h0, 2'h3, 4'h9);
		rows[2] = mk(2'h2, 22'h2aa400, 4'h5, 2'h1, 4'h0);
		rows[3] = mk(2'h0, 22'h2aa400, 4'h0, 2'h1, 4'h1);
		rows[4] = mk(2'h1, 22'h3fffff, 4'h1, 2'h0, 4'h0);
		rows[5] = mk(2'h0, 22'h3fffff, 4'h0, 2'h0, 4'h1);
		tick(3);
		rst_i = 1'b0;
		for (i = 0; i < 6; i++) do_req(rows[i]);
		$display("table rows done");
		// Init is checked after the table: counts start over on a reset
		for (i = 0; i < 100; i++) do_req(rows[1]);
		$display("read stream done");
		falls = 0;
		tick(8100);
		chk(falls >= 2 && falls <= 3, 16'h1);
		$display("idle refresh done");
		wait_hi(req_ready_o, 20000);
		req_i = rows[1].req;
		req_valid_i = 1'b1;
		tick(1);
		req_valid_i = 1'b0;
		tick(4);
		rst_i = 1'b1;
		tick(3);
		chk({pins_o.ras_n, pins_o.cas_n, pins_o.we_n, init_done_o,
			req_ready_o}, 16'h1c);
		rst_i = 1'b0;
		falls = 0;
		// Enable low must freeze the pause timer as well
		ce_i = 1'b0;
		tick(10);
		ce_i = 1'b1;
		for (i = 10; i < 210 && pins_o.ras_n === 1'b1; i++) tick(1);
		chk(i >= PAUSE + 10, 16'h1);
		wait_hi(init_done_o, 2000);
		chk(falls, 16'h8);
		do_req(rows[1]);
		$display("reset and init done");
		close_out();
	end
endmodule

bind nibble_dram_ctrl nibble_dram_ctrl_assertions #(
	.INIT_PAUSE_CYC(INIT_PAUSE_CYC), .USE_CBR(USE_CBR)) u_chk (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
	.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
	.init_done_o(init_done_o), .pins_o(pins_o), .dout_i(dout_i));
